// ### i2c_cfg_params.svh
// Constants for the two-wire configuration port
`ifndef I2C_CFG_PARAMS_SVH
`define I2C_CFG_PARAMS_SVH
`define SLAVE_ADDR_HI  5'h16
`define REG_COUNT      8
`define BITS_PER_BYTE  4'h8
`define REG_RESET      8'h00
`define PD_A_BIT       13
`define PD_B_BIT       53
`endif

// ### i2c_cfg_pkg.sv
// Types for the two-wire configuration port
package i2c_cfg_pkg;
	typedef enum logic [2:0] {
		st_idle  = 3'h0,
		st_addr  = 3'h1,
		st_ack   = 3'h3,
		st_rx    = 3'h2,
		st_tx    = 3'h6,
		st_mack  = 3'h7,
		st_mnext = 3'h5
	} slave_state_t;
	typedef logic [7:0] reg_byte_t;
endpackage : i2c_cfg_pkg

// ### i2c_slave_config_port.sv
// Two-wire slave port with an eight-byte configuration bank
`timescale 1ns/1ps
`include "i2c_cfg_params.svh"
module i2c_slave_config_port import i2c_cfg_pkg::*; (
	// System side
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Link side
	input  wire logic        link_clk,
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	// Address straps
	input  wire logic        addr_strap_low,
	input  wire logic        addr_strap_high,
	// Configuration out
	output logic [63:0]      config_bits,
	output logic             power_down_a,
	output logic             power_down_b
);
	// Link reset: asserted at once, released in step with link_clk
	logic [1:0]   rst_link_sync;
	logic         rst_link;
	logic [1:0]   scl_sync;
	logic [1:0]   sda_sync;
	logic [1:0]   a0_sync;
	logic [1:0]   a1_sync;
	logic         scl_q;
	logic         sda_q;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_cond;
	logic         stop_cond;
	logic         addr_match;
	slave_state_t state;
	logic [3:0]   bit_cnt;
	reg_byte_t    shift;
	logic         rw;
	logic         have_ptr;
	logic [2:0]   ptr;
	logic         wr_en;
	logic         wr_tgl;
	reg_byte_t    bank [`REG_COUNT];
	logic [2:0]   tgl_sync;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			rst_link_sync <= 2'h3;
		end else begin
			rst_link_sync <= {rst_link_sync[0], 1'b0};
		end
	end
	assign rst_link = rst_link_sync[1];

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge link_clk or posedge rst_link) begin
		if (rst_link) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			a0_sync  <= 2'h0;
			a1_sync  <= 2'h0;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl};
			sda_sync <= {sda_sync[0], sda_in};
			a0_sync  <= {a0_sync[0], addr_strap_low};
			a1_sync  <= {a1_sync[0], addr_strap_high};
			scl_q    <= scl_sync[1];
			sda_q    <= sda_sync[1];
		end
	end

	assign scl_rise   = scl_sync[1] & ~scl_q;
	assign scl_fall   = ~scl_sync[1] & scl_q;
	assign start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
	assign stop_cond  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
	// General call (all zero) never matches the fixed upper bits
	assign addr_match = shift[7:1] == {`SLAVE_ADDR_HI, a1_sync[1], a0_sync[1]};
	assign wr_en = (state == st_rx) && scl_fall && (bit_cnt == `BITS_PER_BYTE) && have_ptr;

	// Byte engine runs on link_clk alone, so ref_clk is not needed to talk
	// START and STOP take priority over any bit activity
	always_ff @(posedge link_clk or posedge rst_link) begin
		if (rst_link) begin
			state    <= st_idle;
			bit_cnt  <= 4'h0;
			shift    <= `REG_RESET;
			rw       <= 1'b0;
			have_ptr <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (start_cond) begin
			state    <= st_addr;
			bit_cnt  <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (stop_cond) begin
			state    <= st_idle;
			sda_oe_n <= 1'b1;
		end else begin
			case (state)
			st_addr, st_rx: begin
				if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
					shift   <= {shift[6:0], sda_sync[1]};
					bit_cnt <= bit_cnt + 4'h1;
				end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
					bit_cnt <= 4'h0;
					if (state == st_rx) begin
						have_ptr <= 1'b1;
						state    <= st_ack;
						sda_oe_n <= 1'b0;
					end else if (addr_match) begin
						rw       <= shift[0];
						have_ptr <= shift[0] ? have_ptr : 1'b0;
						state    <= st_ack;
						sda_oe_n <= 1'b0;
					end else begin
						state <= st_idle;
					end
				end
			end
			st_ack: begin
				if (scl_fall) begin
					if (rw) begin
						state    <= st_tx;
						shift    <= bank[ptr];
						sda_oe_n <= bank[ptr][7];
						bit_cnt  <= 4'h1;
					end else begin
						state    <= st_rx;
						sda_oe_n <= 1'b1;
					end
				end
			end
			st_tx: begin
				if (scl_fall) begin
					if (bit_cnt == `BITS_PER_BYTE) begin
						state    <= st_mack;
						sda_oe_n <= 1'b1;
					end else begin
						shift    <= {shift[6:0], 1'b0};
						sda_oe_n <= shift[6];
						bit_cnt  <= bit_cnt + 4'h1;
					end
				end
			end
			st_mack: begin
				if (scl_rise) begin
					state <= sda_sync[1] ? st_idle : st_mnext;
				end
			end
			st_mnext: begin
				if (scl_fall) begin
					state    <= st_tx;
					shift    <= bank[ptr];
					sda_oe_n <= bank[ptr][7];
					bit_cnt  <= 4'h1;
				end
			end
			default: begin
				sda_oe_n <= 1'b1;
				if (state != st_idle) begin
					state <= st_idle;
				end
			end
			endcase
		end
	end

	// Open-drain data: only the enable moves
	always_ff @(posedge link_clk or posedge rst_link) begin
		if (rst_link) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// Pointer: loaded from the first byte, advanced per byte, wraps mod 8
	always_ff @(posedge link_clk or posedge rst_link) begin
		if (rst_link) begin
			ptr <= 3'h0;
		end else if (!start_cond && !stop_cond) begin
			if (state == st_rx && scl_fall && bit_cnt == `BITS_PER_BYTE && !have_ptr) begin
				ptr <= shift[2:0];
			end else if (wr_en) begin
				ptr <= ptr + 3'h1;
			end else if ((state == st_ack && rw) || state == st_mnext) begin
				ptr <= scl_fall ? ptr + 3'h1 : ptr;
			end
		end
	end

	// Bank written only at the acknowledge, so a cut byte never lands
	always_ff @(posedge link_clk or posedge rst_link) begin
		if (rst_link) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				bank[i] <= `REG_RESET;
			end
			wr_tgl <= 1'b0;
		end else if (wr_en && !start_cond && !stop_cond) begin
			bank[ptr] <= shift;
			wr_tgl    <= ~wr_tgl;
		end
	end

	// Toggle crossing; bank is stable for a full bit time after each write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tgl_sync <= 3'h0;
		end else begin
			tgl_sync <= {tgl_sync[1:0], wr_tgl};
		end
	end

	generate
		for (genvar g = 0; g < `REG_COUNT; g++) begin : g_copy
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					config_bits[g*8 +: 8] <= `REG_RESET;
				end else if (tgl_sync[2] != tgl_sync[1]) begin
					config_bits[g*8 +: 8] <= bank[g];
				end
			end
		end
	endgenerate

	// Power-down bits only drive outputs; the port keeps running
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			power_down_a <= 1'b0;
			power_down_b <= 1'b0;
		end else if (tgl_sync[2] != tgl_sync[1]) begin
			power_down_a <= bank[`PD_A_BIT / 8][`PD_A_BIT % 8];
			power_down_b <= bank[`PD_B_BIT / 8][`PD_B_BIT % 8];
		end
	end

	sequence s_addr_done;
		state == st_addr && scl_fall && bit_cnt == `BITS_PER_BYTE && !start_cond && !stop_cond;
	endsequence

	sequence s_data_ack;
		wr_en && !start_cond && !stop_cond;
	endsequence

	property p_mismatch_quiet;
		@(posedge link_clk) disable iff (rst_link)
		s_addr_done and !addr_match |=> sda_oe_n && state == st_idle;
	endproperty
	a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("Ack on foreign address");

	property p_general_call;
		@(posedge link_clk) disable iff (rst_link)
		s_addr_done and shift[7:1] == 7'h00 |=> sda_oe_n;
	endproperty
	a_general_call: assert property (p_general_call) else $error("General call acked");

	property p_addr_ack;
		@(posedge link_clk) disable iff (rst_link)
		s_addr_done and addr_match |=> !sda_oe_n && state == st_ack;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("Own address not acked");

	property p_start;
		@(posedge link_clk) disable iff (rst_link)
		start_cond |=> state == st_addr && bit_cnt == 4'h0 && sda_oe_n;
	endproperty
	a_start: assert property (p_start) else $error("START not taken");

	property p_stop;
		@(posedge link_clk) disable iff (rst_link)
		stop_cond && !start_cond |=> state == st_idle && sda_oe_n;
	endproperty
	a_stop: assert property (p_stop) else $error("STOP not taken");

	property p_write_lands;
		@(posedge link_clk) disable iff (rst_link)
		s_data_ack |=> bank[$past(ptr)] == $past(shift) && ptr == $past(ptr) + 3'h1;
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("Write not stored");

	property p_wrap;
		@(posedge link_clk) disable iff (rst_link)
		s_data_ack and ptr == 3'h7 |=> ptr == 3'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Pointer did not wrap");

	property p_nack_release;
		@(posedge link_clk) disable iff (rst_link)
		state == st_mack && scl_rise && sda_sync[1] && !start_cond && !stop_cond
		|=> sda_oe_n && state == st_idle;
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("SDA held after nack");

	property p_ptr_kept;
		@(posedge link_clk) disable iff (rst_link)
		start_cond |=> ptr == $past(ptr);
	endproperty
	a_ptr_kept: assert property (p_ptr_kept) else $error("Pointer lost on START");

	property p_cfg_follows;
		@(posedge ref_clk) disable iff (rst)
		tgl_sync[2] != tgl_sync[1] |=> config_bits[7:0] == $past(bank[0]);
	endproperty
	a_cfg_follows: assert property (p_cfg_follows) else $error("Config copy missed");

endmodule : i2c_slave_config_port

// ### i2c_cfg_master.sv
// Bus master model driving SCL and an open-drain SDA
`timescale 1ns/1ps
module i2c_cfg_master (
	// Clock and bus
	input  wire logic ref_clk,
	input  wire logic sda_bus,
	output logic      scl,
	output logic      sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	// Works from idle or from SCL low, so it is also the repeated START
	task automatic start();
		sda_drv <= 1'b1;
		tick(1);
		scl <= 1'b1;
		tick(2);
		sda_drv <= 1'b0;
		tick(2);
		scl <= 1'b0;
		tick(1);
	endtask : start
	task automatic stop();
		sda_drv <= 1'b0;
		tick(1);
		scl <= 1'b1;
		tick(2);
		sda_drv <= 1'b1;
		tick(2);
	endtask : stop
	// SDA moves a cycle after SCL falls, well after the slave's answer lands
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		tick(1);
		scl <= 1'b1;
		tick(2);
		r = sda_bus;
		scl <= 1'b0;
		tick(1);
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(mack, ack);
	endtask : xfer
endmodule : i2c_cfg_master

// ### i2c_slave_config_port_test.sv
// Self-checking bench for the two-wire configuration port
`timescale 1ns/1ps
`include "i2c_cfg_params.svh"
module i2c_slave_config_port_test;
	import i2c_cfg_pkg::*;
	logic        ref_clk, link_clk, rst, strap_lo, strap_hi;
	wire logic   scl, sda_drv, sda_out, sda_oe_n, pd_a, pd_b;
	wire logic   [63:0] cfg;
	wire logic   sda_bus = sda_oe_n ? sda_drv : sda_out;
	reg_byte_t   bank [8];
	int          n_mismatch, n_compared;
	`define CHK(nm, e, g) begin \
		n_compared++; \
		if ((g) !== (e)) begin \
			$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
			n_mismatch++; \
		end \
	end
	i2c_slave_config_port u_dut (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
		.scl(scl), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.addr_strap_low(strap_lo), .addr_strap_high(strap_hi), .config_bits(cfg),
		.power_down_a(pd_a), .power_down_b(pd_b));
	i2c_cfg_master u_mst (.ref_clk(ref_clk), .sda_bus(sda_bus), .scl(scl),
		.sda_drv(sda_drv));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = ~link_clk;
	end
	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic chk_bank();
		for (int i = 0; i < 8; i++)
			`CHK("config_bits", bank[i], cfg[8*i +: 8])
		`CHK("power_down_a", bank[1][5], pd_a)
		`CHK("power_down_b", bank[6][5], pd_b)
	endtask : chk_bank
	task automatic addr(input logic [1:0] a, input logic rw, input logic exp);
		logic [7:0] q;
		logic       ack;
		u_mst.xfer({`SLAVE_ADDR_HI, a, rw}, 1'b1, q, ack);
		`CHK("addr ack", exp, ack)
	endtask : addr
	task automatic set_ptr(input logic [2:0] p);
		logic [7:0] q;
		logic       ack;
		u_mst.start();
		addr({strap_hi, strap_lo}, 1'b0, 1'b0);
		u_mst.xfer({5'h00, p}, 1'b1, q, ack);
		`CHK("ptr ack", 1'b0, ack)
	endtask : set_ptr
	task automatic t_addr();
		logic [7:0] q;
		logic       ack;
		for (int s = 0; s < 4; s++) begin
			strap_lo <= s[0];
			strap_hi <= s[1];
			u_mst.tick(4);
			u_mst.start();
			addr(s[1:0] ^ 2'h1, 1'b0, 1'b1);
			u_mst.xfer(8'h00, 1'b1, q, ack);
			`CHK("ignored ack", 1'b1, ack)
			u_mst.start();
			u_mst.xfer(8'h00, 1'b1, q, ack);
			`CHK("general call", 1'b1, ack)
			u_mst.start();
			addr(s[1:0], 1'b0, 1'b0);
			u_mst.stop();
		end
		chk_bank();
		$display("t_addr done");
	endtask : t_addr
	// Registers are checked before STOP, so each byte must land at its own ack
	task automatic t_write(input logic [2:0] p, input int n);
		logic [7:0] q, d;
		logic       ack;
		set_ptr(p);
		for (int i = 0; i < n; i++) begin
			d = 8'h3c + 8'h1b * i[7:0];
			u_mst.xfer(d, 1'b1, q, ack);
			`CHK("data ack", 1'b0, ack)
			bank[p + i[2:0]] = d;
			u_mst.tick(2);
			chk_bank();
		end
		u_mst.stop();
		$display("t_write done");
	endtask : t_write
	task automatic t_abort();
		logic q;
		set_ptr(3'h2);
		for (int i = 0; i < 4; i++)
			u_mst.bit_io(1'b1, q);
		u_mst.stop();
		u_mst.tick(4);
		chk_bank();
		$display("t_abort done");
	endtask : t_abort
	task automatic t_read(input logic [2:0] p);
		logic [7:0] q;
		logic       ack;
		set_ptr(p);
		u_mst.start();
		addr({strap_hi, strap_lo}, 1'b1, 1'b0);
		for (int i = 0; i < 8; i++) begin
			u_mst.xfer(8'hff, i == 7, q, ack);
			`CHK("read byte", bank[p + i[2:0]], q)
		end
		u_mst.tick(2);
		`CHK("sda_oe_n", 1'b1, sda_oe_n)
		u_mst.stop();
		$display("t_read done");
	endtask : t_read
	initial begin
		rst = 1'b1;
		strap_lo = 1'b0;
		strap_hi = 1'b0;
		n_mismatch = 0;
		n_compared = 0;
		for (int i = 0; i < 8; i++)
			bank[i] = `REG_RESET;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		u_mst.tick(4);
		chk_bank();
		`CHK("sda idle", 1'b1, sda_oe_n)
		t_addr();
		t_write(3'h6, 9);
		t_write(3'h1, 1);
		t_abort();
		t_read(3'h5);
		t_read(3'h0);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		close_out();
	end
endmodule : i2c_slave_config_port_test
